// ---- rtl/stack_excl_defs.svh ----
// Function
// - store: lowest register at lowest address
// - load: lowest register from lowest address
// - store top address is stack pointer minus four
// - load bottom address is stack pointer
// - after store, pointer is lowest stored word
// - after load, pointer is above highest word
// - acts as decrement-before store, increment-after load
// - popped counter branches, bit 0 sets state
// - exclusive load reads sized data, reserves address
// - exclusive address is base plus offset for word size, base alone for byte and halfword
// - status 0 when stored, 1 when not
// - success only without foreign access since load
// - drop reservation makes next store fail
// - drop reservation leaves flags unchanged
// - these transfers leave flags unchanged
// - words sit at consecutive 4-byte addresses
`ifndef STACK_EXCL_DEFS_SVH
`define STACK_EXCL_DEFS_SVH
`define WORD_STEP       32'h0000_0004
`define SP_INDEX        4'hD
`define LR_INDEX        4'hE
`define PC_INDEX        4'hF
`define STATUS_PASS     32'h0000_0000
`define STATUS_FAIL     32'h0000_0001
`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define SIZE_WORD       2'h2
`define OFFSET_MAX      32'h0000_03FC
`endif

// ---- rtl/stack_excl_pkg.sv ----
package stack_excl_pkg;
   typedef enum logic [2:0] {
      OP_NONE       = 3'h0,
      OP_PUSH       = 3'h1,
      OP_POP        = 3'h2,
      OP_LOAD_EXCL  = 3'h3,
      OP_STORE_EXCL = 3'h4,
      OP_DROP_EXCL  = 3'h5
   } op_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_BEAT  = 3'h1,
      ST_WAIT  = 3'h2,
      ST_XLOAD = 3'h3,
      ST_XSTOR = 3'h4,
      ST_DONE  = 3'h5
   } state_t;
endpackage : stack_excl_pkg

// ---- rtl/excl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stack_excl_defs.svh"
module excl_monitor
   import stack_excl_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n_sync,
   input  wire logic        set_valid,
   input  wire logic [31:0] set_addr,
   input  wire logic [1:0]  set_size,
   input  wire logic        drop,
   input  wire logic        snoop_valid,
   input  wire logic [31:0] snoop_addr,
   input  wire logic [31:0] check_addr,
   input  wire logic [1:0]  check_size,
   output logic             pass
);
   logic        held_q;
   logic [31:0] addr_q;
   logic [1:0]  size_q;

   // a foreign access to the reserved word cancels it; word granularity is safe-side
   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         held_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         size_q <= 2'h0;
      end else if (set_valid) begin
         held_q <= 1'b1;
         addr_q <= set_addr;
         size_q <= set_size;
      end else if (drop) begin
         held_q <= 1'b0;
      end else if (snoop_valid && snoop_addr[31:2] == addr_q[31:2]) begin
         held_q <= 1'b0;
      end
   end

   assign pass = held_q && (check_addr == addr_q) && (check_size == size_q);
endmodule : excl_monitor
`default_nettype wire

// ---- rtl/stack_excl_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stack_excl_defs.svh"
module stack_excl_unit
   import stack_excl_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // instruction side
   input  wire logic        req_valid,
   input  wire op_t         req_op,
   input  wire logic [15:0] req_reglist,
   input  wire logic [31:0] req_sp,
   input  wire logic [31:0] req_base,
   input  wire logic [31:0] req_offset,
   input  wire logic [1:0]  req_size,
   input  wire logic [31:0] req_store_data,
   output logic             req_ready,
   // register file read for push
   output logic [3:0]       rf_rd_idx,
   input  wire logic [31:0] rf_rd_data,
   // register file write
   output logic             rf_wr_en,
   output logic [3:0]       rf_wr_idx,
   output logic [31:0]      rf_wr_data,
   output logic             sp_wr_en,
   output logic [31:0]      sp_wr_data,
   output logic             branch_en,
   output logic [31:0]      branch_target,
   output logic             thumb_bit,
   output logic             flags_wr_en,
   // data memory
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   output logic [1:0]       mem_size,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   // accesses by other agents
   input  wire logic        snoop_valid,
   input  wire logic [31:0] snoop_addr
);
   logic        rst_s1_q;
   logic        rst_s2_q;
   state_t      state_q;
   op_t         op_q;
   logic [15:0] left_q;
   logic [31:0] addr_q;
   logic [31:0] sp_final_q;
   logic [3:0]  xreg_q;
   logic [1:0]  xsize_q;
   logic [31:0] xdata_q;
   logic        mon_pass;
   logic        mon_set;
   logic        mon_drop;
   logic        branch_target_pending;

   function automatic logic [5:0] count_regs(input logic [15:0] l);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 16; i++) begin
         n = n + {5'h00, l[i]};
      end
      return n;
   endfunction : count_regs

   function automatic logic [3:0] lowest_reg(input logic [15:0] l);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (l[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : lowest_reg

   // whole stack block size in bytes
   function automatic logic [31:0] span(input logic [15:0] l);
      return {24'h00_0000, count_regs(l), 2'h0};
   endfunction : span

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign mon_set  = (state_q == ST_XLOAD) && mem_ack;
   assign mon_drop = (state_q == ST_IDLE) && req_valid && req_op == OP_DROP_EXCL;
   // a store-exclusive also ends the reservation whatever its result
   excl_monitor u_mon (
      .ref_clk     (ref_clk),
      .rst_n_sync  (rst_s2_q),
      .set_valid   (mon_set),
      .set_addr    (addr_q),
      .set_size    (xsize_q),
      .drop        (mon_drop || state_q == ST_XSTOR),
      .snoop_valid (snoop_valid),
      .snoop_addr  (snoop_addr),
      .check_addr  (addr_q),
      .check_size  (xsize_q),
      .pass        (mon_pass)
   );

   assign rf_rd_idx = lowest_reg(left_q);

   // sequencing and memory requests
   always_ff @(posedge ref_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         state_q    <= ST_IDLE;
         op_q       <= OP_NONE;
         left_q     <= 16'h0000;
         addr_q     <= 32'h0000_0000;
         sp_final_q <= 32'h0000_0000;
         xreg_q     <= 4'h0;
         xsize_q    <= `SIZE_WORD;
         xdata_q    <= 32'h0000_0000;
         req_ready  <= 1'b0;
         mem_req    <= 1'b0;
         mem_we     <= 1'b0;
         mem_addr   <= 32'h0000_0000;
         mem_wdata  <= 32'h0000_0000;
         mem_size   <= `SIZE_WORD;
      end else begin
         req_ready <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  op_q    <= req_op;
                  left_q  <= req_reglist;
                  xreg_q  <= req_reglist[3:0];
                  xsize_q <= req_size;
                  xdata_q <= req_store_data;
                  case (req_op)
                     OP_PUSH: begin
                        addr_q     <= req_sp - span(req_reglist);
                        sp_final_q <= req_sp - span(req_reglist);
                        state_q    <= ST_BEAT;
                     end
                     OP_POP: begin
                        addr_q     <= req_sp;
                        sp_final_q <= req_sp + span(req_reglist);
                        state_q    <= ST_BEAT;
                     end
                     OP_LOAD_EXCL: begin
                        addr_q  <= (req_size == `SIZE_WORD) ? req_base + req_offset
                                                            : req_base;
                        state_q <= ST_XLOAD;
                     end
                     OP_STORE_EXCL: begin
                        addr_q  <= (req_size == `SIZE_WORD) ? req_base + req_offset
                                                            : req_base;
                        state_q <= ST_XSTOR;
                     end
                     default: begin
                        state_q <= ST_DONE;
                     end
                  endcase
               end
            end
            ST_BEAT: begin
               // ascending order from the lowest register keeps both directions simple
               mem_req   <= 1'b1;
               mem_we    <= (op_q == OP_PUSH);
               mem_addr  <= addr_q;
               mem_wdata <= rf_rd_data;
               mem_size  <= `SIZE_WORD;
               state_q   <= ST_WAIT;
            end
            ST_WAIT: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we  <= 1'b0;
                  left_q[lowest_reg(left_q)] <= 1'b0;
                  addr_q  <= addr_q + `WORD_STEP;
                  state_q <= (count_regs(left_q) == 6'h01) ? ST_DONE : ST_BEAT;
               end
            end
            ST_XLOAD: begin
               mem_req  <= ~mem_ack;
               mem_we   <= 1'b0;
               mem_addr <= addr_q;
               mem_size <= xsize_q;
               if (mem_ack) begin
                  state_q <= ST_DONE;
               end
            end
            ST_XSTOR: begin
               // store only goes out if the reservation still holds
               mem_req   <= mon_pass;
               mem_we    <= mon_pass;
               mem_addr  <= addr_q;
               mem_wdata <= xdata_q;
               mem_size  <= xsize_q;
               state_q   <= mon_pass ? ST_WAIT : ST_DONE;
               left_q    <= 16'h0001;
               op_q      <= mon_pass ? OP_STORE_EXCL : OP_NONE;
            end
            default: begin
               req_ready <= 1'b1;
               state_q   <= ST_IDLE;
            end
         endcase
      end
   end

   // register file, pointer and branch updates
   always_ff @(posedge ref_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rf_wr_en      <= 1'b0;
         rf_wr_idx     <= 4'h0;
         rf_wr_data    <= 32'h0000_0000;
         sp_wr_en      <= 1'b0;
         sp_wr_data    <= 32'h0000_0000;
         branch_en     <= 1'b0;
         branch_target <= 32'h0000_0000;
         thumb_bit     <= 1'b1;
         flags_wr_en   <= 1'b0;
      end else begin
         rf_wr_en  <= 1'b0;
         sp_wr_en  <= 1'b0;
         branch_en <= 1'b0;
         if (state_q == ST_WAIT && mem_ack && op_q == OP_POP) begin
            if (lowest_reg(left_q) == `PC_INDEX) begin
               branch_target <= {mem_rdata[31:1], 1'b0};
               thumb_bit     <= mem_rdata[0];
            end else begin
               rf_wr_en   <= 1'b1;
               rf_wr_idx  <= lowest_reg(left_q);
               rf_wr_data <= mem_rdata;
            end
         end
         if (state_q == ST_XLOAD && mem_ack) begin
            rf_wr_en   <= 1'b1;
            rf_wr_idx  <= xreg_q;
            rf_wr_data <= (xsize_q == `SIZE_BYTE) ? {24'h00_0000, mem_rdata[7:0]}
                        : (xsize_q == `SIZE_HALF) ? {16'h0000, mem_rdata[15:0]}
                        : mem_rdata;
         end
         if (state_q == ST_XSTOR && !mon_pass) begin
            rf_wr_en   <= 1'b1;
            rf_wr_idx  <= xreg_q;
            rf_wr_data <= `STATUS_FAIL;
         end
         if (state_q == ST_WAIT && mem_ack && op_q == OP_STORE_EXCL) begin
            rf_wr_en   <= 1'b1;
            rf_wr_idx  <= xreg_q;
            rf_wr_data <= `STATUS_PASS;
         end
         if (state_q == ST_DONE && (op_q == OP_PUSH || op_q == OP_POP)) begin
            sp_wr_en   <= 1'b1;
            sp_wr_data <= sp_final_q;
            branch_en  <= (op_q == OP_POP) && left_q == 16'h0000 && branch_target_pending;
         end
      end
   end

   // remember that the counter was popped so the branch is raised in the same cycle as the pointer update
   always_ff @(posedge ref_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         branch_target_pending <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         branch_target_pending <= req_valid && req_op == OP_POP && req_reglist[`PC_INDEX];
      end
   end
endmodule : stack_excl_unit
`default_nettype wire

// ---- bench/stack_excl_unit_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module stack_excl_unit_assertions
   import stack_excl_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        req_valid,
   input wire op_t         req_op,
   input wire logic [15:0] req_reglist,
   input wire logic [31:0] req_sp,
   input wire logic [31:0] req_base,
   input wire logic [31:0] req_offset,
   input wire logic        req_ready,
   input wire logic        sp_wr_en,
   input wire logic [31:0] sp_wr_data,
   input wire logic        branch_en,
   input wire logic [31:0] branch_target,
   input wire logic        thumb_bit,
   input wire logic        flags_wr_en,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_ack
);
   // shadow of the operation in flight; gives expected addresses without peeking inside
   logic        busy_q, first_q, push_q, multi_q;
   logic [31:0] base_q, next_q;
   wire logic   take = req_valid && !busy_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         first_q <= 1'b0;
         push_q <= 1'b0;
         multi_q <= 1'b0;
         base_q <= 32'h0;
      end else if (take) begin
         busy_q <= 1'b1;
         first_q <= 1'b1;
         push_q <= req_op == OP_PUSH;
         multi_q <= req_op == OP_PUSH || req_op == OP_POP;
         base_q <= req_op == OP_PUSH ? req_sp - 32'($countones(req_reglist) * 4) :
                   req_op == OP_POP ? req_sp : req_base + req_offset;
      end else begin
         if (req_ready) busy_q <= 1'b0;
         if (mem_req && mem_ack) first_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk)
      if (mem_req && mem_ack) next_q <= mem_addr + 32'h4;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   flags_held_a: assert property (!flags_wr_en)
      else $error("flags written");
   req_hold_a: assert property (mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("request moved");
   first_addr_a: assert property (mem_req && first_q |-> mem_addr == base_q)
      else $error("first address");
   beat_step_a: assert property (mem_req && multi_q && !first_q |-> mem_addr == next_q)
      else $error("beat address");
   beat_dir_a: assert property (mem_req && multi_q |-> mem_we == push_q)
      else $error("beat direction");
   push_sp_a: assert property (sp_wr_en && push_q |-> sp_wr_data == base_q)
      else $error("push pointer");
   pop_sp_a: assert property (sp_wr_en && multi_q && !push_q |-> sp_wr_data == next_q)
      else $error("pop pointer");
   sp_last_a: assert property (sp_wr_en |-> !mem_req ##[0:2] req_ready)
      else $error("pointer not last");
   branch_state_a: assert property (branch_en |-> sp_wr_en && !branch_target[0] && thumb_bit)
      else $error("branch state");
   drop_quick_a: assert property (take && req_op == OP_DROP_EXCL |=>
      !mem_req throughout (##[0:2] req_ready)) else $error("drop slow");
endmodule : stack_excl_unit_assertions
`default_nettype wire

// ---- bench/data_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
   input wire logic        ref_clk,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [3:0]  delay,
   output logic            mem_ack,
   output logic [31:0]     mem_rdata
);
   logic [31:0] mem [logic [31:0]];
   int          cnt = 0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 32'h0;
   // idle data toggles so a read taken off the ack cycle never passes
   always @(posedge ref_clk) begin
      if (mem_req && !mem_ack && cnt >= delay) begin
         cnt = 0;
         mem_ack <= 1'b1;
         if (mem_we) mem[mem_addr] = mem_wdata;
         mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
      end else begin
         cnt = cnt + int'(mem_req && !mem_ack);
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : data_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import stack_excl_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        req_valid = 1'b0;
   op_t         req_op = OP_NONE;
   logic [15:0] req_reglist = 16'h0;
   logic [31:0] req_sp = 32'h0;
   logic [31:0] req_base = 32'h0;
   logic [31:0] req_offset = 32'h0;
   logic [31:0] req_store_data = 32'h0;
   logic [1:0]  req_size = 2'h2;
   logic        snoop_valid = 1'b0;
   logic [31:0] snoop_addr = 32'h0;
   logic [3:0]  mem_delay = 4'h0;
   logic        req_ready, rf_wr_en, sp_wr_en, branch_en, thumb_bit, flags_wr_en;
   logic        mem_req, mem_we, mem_ack;
   logic [3:0]  rf_rd_idx, rf_wr_idx;
   logic [31:0] rf_rd_data, rf_wr_data, sp_wr_data, branch_target;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, sp_seen, br_seen;
   logic [31:0] rf_seen [16];
   int          errors = 0;
   int          tests_run = 0;
   int          br_cnt = 0;
   int          wr_cnt = 0;
   int          cycles = 0;
   stack_excl_unit i_stack_excl_unit (.*, .mem_size());
   data_mem_model i_data_mem_model (.*, .delay(mem_delay));
   always #12.5 ref_clk = ~ref_clk;
   assign rf_rd_data = {28'hC0DE000, rf_rd_idx};
   always @(posedge ref_clk) begin
      cycles++;
      if (rf_wr_en === 1'b1) rf_seen[rf_wr_idx] = rf_wr_data;
      if (sp_wr_en === 1'b1) sp_seen = sp_wr_data;
      if (branch_en === 1'b1) br_cnt++;
      if (branch_en === 1'b1) br_seen = branch_target;
      if (mem_ack === 1'b1 && mem_we === 1'b1) wr_cnt++;
      // the run needs under two hundred cycles, so this trips only on a hang
      if (cycles == 5000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // one request, then one spare edge so the monitor has logged every pulse
   task automatic go(input op_t op);
      req_op <= op;
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      @(posedge ref_clk);
   endtask : go
   task automatic t_push(input logic [15:0] rl, input logic [31:0] sp);
      logic [31:0] a;
      a = sp - 32'($countones(rl) * 4);
      req_reglist <= rl;
      req_sp <= sp;
      go(OP_PUSH);
      check(sp_seen, a);
      for (int i = 0; i < 16; i++) begin
         if (rl[i]) begin
            check(i_data_mem_model.mem[a], {28'hC0DE000, 4'(i)});
            a += 32'h4;
         end
      end
      $display("push test done");
   endtask : t_push
   task automatic t_pop(input logic [15:0] rl, input logic [31:0] sp);
      logic [31:0] a;
      int          b;
      a = sp;
      b = br_cnt;
      for (int i = 0; i < 16; i++) begin
         if (rl[i]) begin
            i_data_mem_model.mem[a] = {sp[19:0], 4'(i), 8'h01};
            a += 32'h4;
         end
      end
      req_reglist <= rl;
      req_sp <= sp;
      mem_delay <= 4'h2;
      go(OP_POP);
      mem_delay <= 4'h0;
      check(sp_seen, a);
      for (int i = 0; i < 15; i++) begin
         if (rl[i]) check(rf_seen[i], {sp[19:0], 4'(i), 8'h01});
      end
      check(32'(br_cnt - b), {31'h0, rl[15]});
      if (rl[15]) check(br_seen, {sp[19:0], 12'hF00});
      check({31'h0, thumb_bit}, 32'h1);
      $display("pop test done");
   endtask : t_pop
   // how: bit 0 load first, bit 1 foreign access, bit 2 drop reservation
   task automatic t_excl(input logic [2:0] how, input logic [31:0] ba, input logic [31:0] off,
                         input logic [1:0] sz, input logic [31:0] st);
      int w;
      i_data_mem_model.mem[ba + off] = ~ba;
      req_base <= ba;
      req_offset <= off;
      req_size <= sz;
      req_store_data <= ba ^ 32'h5EED_0000;
      if (how[0]) begin
         req_reglist <= 16'h0003;
         go(OP_LOAD_EXCL);
         if (sz == 2'h2) check(rf_seen[3], ~ba);
      end
      if (how[1]) begin
         snoop_valid <= 1'b1;
         snoop_addr <= ba + off;
         @(posedge ref_clk);
         snoop_valid <= 1'b0;
      end
      if (how[2]) go(OP_DROP_EXCL);
      w = wr_cnt;
      rf_seen[4] = 32'hFFFF_FFFF;
      req_reglist <= 16'h0004;
      go(OP_STORE_EXCL);
      check(rf_seen[4], st);
      check(32'(wr_cnt - w), st ^ 32'h1);
      if (st == 32'h0 && sz == 2'h2) check(i_data_mem_model.mem[ba + off], req_store_data);
      $display("exclusive test done");
   endtask : t_excl
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_excl(3'h0, 32'h2000_0000, 32'h0, 2'h2, 32'h1);
      for (int s = 0; s < 3; s++) t_excl(3'h1, 32'h2000_0100 + 32'(s * 16), 32'h0, 2'(s), 32'h0);
      t_excl(3'h1, 32'h2000_0200, 32'h3FC, 2'h2, 32'h0);
      t_excl(3'h0, 32'h2000_0200, 32'h3FC, 2'h2, 32'h1);
      t_excl(3'h3, 32'h2000_0300, 32'h8, 2'h2, 32'h1);
      t_excl(3'h5, 32'h2000_0400, 32'h0, 2'h2, 32'h1);
      t_push(16'h400B, 32'h0000_0100);
      t_push(16'h0080, 32'h0000_2004);
      t_pop(16'h8024, 32'h0000_0200);
      t_pop(16'h4000, 32'h0000_0300);
      report_and_stop();
   end
endmodule : tb_top
bind stack_excl_unit stack_excl_unit_assertions i_stack_excl_unit_assertions (.*);
`default_nettype wire
